//--- core/sar_adc_control_sequencer.sv
// converter control sequencer: registers, input and reference routing, conversion sequence
//
// Behaviour
// - reference code 01 selects analog supply
// - reference code 10 selects amplifier output
// - codes 00 and 11 use external pin
// - analog pin loses its digital functions
// - pull-high removed on analog pins
// - direction setting ignored on analog pins
// - external source routes channels 0 to 3
// - channel codes 0100 up leave input floating
// - source codes 001 to 011 ground input
// - source code 100 converts supply over four
// - start written low-high-low begins conversion
// - busy set once conversion starts
// - busy cleared when conversion completes
// - completion raises converter interrupt request
// - conversion clock is power-of-two divided
// - power enable bit powers converter circuitry
// - four sampling then ten converting cycles
// - result aligned by alignment select, zeros elsewhere
// - result bytes kept while converter disabled
`timescale 1ns/100ps
`default_nettype none

module sar_adc_control_sequencer
   import sar_adc_control_pkg::*;
(
   input wire logic i_core_clk,                   // system clock, 25 MHz
   input wire logic i_reset,                      // asynchronous reset, active high
   input wire logic [4:0] i_avs_address,          // avalon byte address
   input wire logic i_avs_read,                   // avalon read request
   input wire logic i_avs_write,                  // avalon write request
   input wire logic [31:0] i_avs_writedata,       // avalon write data
   input wire logic [3:0] i_avs_byteenable,       // avalon byte enables
   output logic [31:0] o_avs_readdata,            // avalon read data, registered
   output logic o_avs_waitrequest,                // avalon wait request
   input wire logic i_comparator_high,            // analog comparator, input above trial code
   input wire logic [3:0] i_pin_pullup_request,   // pull-high enables from port logic
   input wire logic [3:0] i_pin_drive_request,    // output-direction enables from port logic
   output var analog_ctrl_type o_analog,          // controls toward the analog macro
   output logic [3:0] o_pin_digital_enable,       // digital path enable per analog pin
   output logic [3:0] o_pin_pullup_enable,        // pull-high enable per analog pin
   output logic [3:0] o_pin_drive_enable,         // output driver enable per analog pin
   output logic o_ref_pin_input_enable,           // reference pin wired to converter
   output logic o_conversion_busy_flag,           // conversion in progress
   output logic o_irq_request                     // one-cycle completion pulse to interrupt controller
);

   ////////////////////////////////////////////////////////////////////////////
   // state and decode signals
   // every flop lives in state_reg

   core_state_type state_reg;   // all registers of the block
   core_state_type state_next;  // next value of all registers
   logic [6:0] div_mask;        // divider mask for the chosen power of two
   logic conv_tick;             // one conversion clock period elapsed
   logic ctrl0_write;           // accepted write to control 0, low byte
   logic ctrl1_write;           // accepted write to control 1, low byte
   logic pin_write;             // accepted write to pin function
   logic start_trigger;         // start bit written back low after high
   logic [RESULT_BITS-1:0] decided; // trial code after this bit's decision
   logic [3:0] analog_pins;     // pins given to the converter
   logic external_source;       // source code routes an external channel
   logic [3:0] channel_onehot;  // pin channel switches

   ////////////////////////////////////////////////////////////////////////////
   // combinational decode that the next-state logic and outputs share

   // conversion clock divider: a tick every 2^clk_sel system clocks
   // a retune mid-run bends one period
   always_comb begin
      div_mask = 7'((8'h01 << state_reg.clk_sel) - 8'h01);
      conv_tick = (state_reg.div_count & div_mask) == div_mask;
   end

   // bus write decode; writes land only at the edge where waitrequest is low
   // lane 0 carries every register
   always_comb begin
      ctrl0_write = state_reg.bus_ack && i_avs_write && i_avs_byteenable[0]
                    && (i_avs_address == CONTROL_0_ADDR);
      ctrl1_write = state_reg.bus_ack && i_avs_write && i_avs_byteenable[0]
                    && (i_avs_address == CONTROL_1_ADDR);
      pin_write = state_reg.bus_ack && i_avs_write && i_avs_byteenable[0]
                  && (i_avs_address == PIN_FUNCTION_ADDR);
   end

   // start pulse: the falling write of a high start bit launches a conversion
   // power must ride in that write
   always_comb begin
      start_trigger = ctrl0_write && state_reg.start_bit
                      && !i_avs_writedata[CTRL0_START_BIT]
                      && i_avs_writedata[CTRL0_POWER_BIT];
   end

   // successive approximation decision for the bit under trial
   // comparator answer is two clocks old
   always_comb begin
      if (state_reg.cmp_sync) begin
         decided = state_reg.trial;
      end else begin
         decided = state_reg.trial & ~state_reg.bit_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic for every register of the block

   always_comb begin
      state_next = state_reg;
      state_next.done_pulse = 1'b0;

      // comparator crosses from the analog domain: two flops before use
      state_next.cmp_meta = i_comparator_high;
      state_next.cmp_sync = state_reg.cmp_meta;

      // free-running divider, realigned at each start
      state_next.div_count = state_reg.div_count + 7'h01;

      // avalon: one wait cycle, read data captured during it
      // bus_ack is also the write strobe
      state_next.bus_ack = (i_avs_read || i_avs_write) && !state_reg.bus_ack;
      if (i_avs_read && !state_reg.bus_ack) begin
         case (i_avs_address)
            CONTROL_0_ADDR: begin
               state_next.readdata = {24'h00_0000, state_reg.start_bit, state_reg.busy,
                                      state_reg.power, state_reg.align, state_reg.channel};
            end
            CONTROL_1_ADDR: begin
               state_next.readdata = {24'h00_0000, state_reg.source, state_reg.ref_sel,
                                      state_reg.clk_sel};
            end
            RESULT_HIGH_ADDR: begin
               state_next.readdata = {24'h00_0000, state_reg.result_high};
            end
            RESULT_LOW_ADDR: begin
               state_next.readdata = {24'h00_0000, state_reg.result_low};
            end
            PIN_FUNCTION_ADDR: begin
               state_next.readdata = {27'h000_0000, state_reg.pin_func};
            end
            default: begin
               // unmapped addresses read as zero
               state_next.readdata = 32'h0000_0000;
            end
         endcase
      end

      // control 0 fields; busy is read-only and never written here
      // kept so the next write sees it fall
      if (ctrl0_write) begin
         state_next.start_bit = i_avs_writedata[CTRL0_START_BIT];
         state_next.power = i_avs_writedata[CTRL0_POWER_BIT];
         state_next.align = i_avs_writedata[CTRL0_ALIGN_BIT];
         state_next.channel = i_avs_writedata[CTRL0_CHANNEL_LSB +: 4];
      end

      // control 1 fields
      // no lock against writes while busy
      if (ctrl1_write) begin
         state_next.source = i_avs_writedata[CTRL1_SOURCE_LSB +: 3];
         state_next.ref_sel = i_avs_writedata[CTRL1_REF_LSB +: 2];
         state_next.clk_sel = i_avs_writedata[CTRL1_CLKDIV_LSB +: 3];
      end

      // pin function: bits 3:0 analog inputs, bit 4 reference pin
      // not checked against the reference
      if (pin_write) begin
         state_next.pin_func = i_avs_writedata[4:0];
      end

      // conversion sequencer
      // aborts below override the case
      case (state_reg.state)
         ST_IDLE: begin
            if (start_trigger) begin
               // first tick a period on
               state_next.state = ST_SAMPLE;
               state_next.busy = 1'b1;
               state_next.div_count = 7'h00;
               state_next.phase_count = 4'h0;
            end
         end
         ST_SAMPLE: begin
            // sampling phase, four conversion clocks
            if (conv_tick) begin
               state_next.phase_count = state_reg.phase_count + 4'h1;
               if (state_reg.phase_count == SAMPLE_TICKS - 4'h1) begin
                  state_next.state = ST_CONVERT;
                  state_next.trial = {1'b1, {(RESULT_BITS-1){1'b0}}};
                  state_next.bit_mask = {1'b1, {(RESULT_BITS-1){1'b0}}};
               end
            end
         end
         ST_CONVERT: begin
            // one bit decided per conversion clock, ten in all
            // last decision lands as busy clears
            if (conv_tick) begin
               if (state_reg.bit_mask[0]) begin
                  state_next.state = ST_IDLE;
                  state_next.busy = 1'b0;
                  state_next.done_pulse = 1'b1;
                  // both bytes written with the busy clear, never half a result
                  if (state_reg.align) begin
                     state_next.result_high = {6'h00, decided[9:8]};
                     state_next.result_low = decided[7:0];
                  end else begin
                     state_next.result_high = decided[9:2];
                     state_next.result_low = {decided[1:0], 6'h00};
                  end
               end else begin
                  state_next.trial = decided | (state_reg.bit_mask >> 1);
                  state_next.bit_mask = state_reg.bit_mask >> 1;
               end
            end
         end
         default: begin
            state_next.state = ST_IDLE;
            state_next.busy = 1'b0;
         end
      endcase

      // raising start, or removing power, abandons a conversion in flight;
      // the result bytes keep their old value, even when a conversion finishes in that same cycle
      if ((ctrl0_write && i_avs_writedata[CTRL0_START_BIT]) || !state_next.power) begin
         state_next.state = ST_IDLE;
         state_next.busy = 1'b0;
         state_next.done_pulse = 1'b0;
         state_next.result_high = state_reg.result_high;
         state_next.result_low = state_reg.result_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the one register stage of the block
   // constants only in reset

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg.state <= ST_IDLE;
         state_reg.start_bit <= 1'b0;
         state_reg.power <= 1'b0;
         state_reg.align <= 1'b0;
         state_reg.channel <= CONTROL_RESET[3:0];
         state_reg.source <= CONTROL_RESET[2:0];
         state_reg.ref_sel <= CONTROL_RESET[1:0];
         state_reg.clk_sel <= CONTROL_RESET[2:0];
         state_reg.pin_func <= CONTROL_RESET[4:0];
         state_reg.busy <= 1'b0;
         state_reg.result_high <= CONTROL_RESET;
         state_reg.result_low <= CONTROL_RESET;
         state_reg.div_count <= 7'h00;
         state_reg.phase_count <= 4'h0;
         state_reg.trial <= 10'h000;
         state_reg.bit_mask <= 10'h000;
         state_reg.cmp_meta <= 1'b0;
         state_reg.cmp_sync <= 1'b0;
         state_reg.bus_ack <= 1'b0;
         state_reg.readdata <= 32'h0000_0000;
         state_reg.done_pulse <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input and reference routing toward the analog macro

   // external channel routing for the source codes that pick a pin
   // other codes open every pin
   always_comb begin
      external_source = (state_reg.source != SOURCE_QUARTER_SUPPLY)
                        && !((state_reg.source >= SOURCE_GROUND_LOW)
                             && (state_reg.source <= SOURCE_GROUND_HIGH));
   end

   // per-channel switch: closed only for an implemented channel code
   // codes 0100 up float the input
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_channel
         assign channel_onehot[ch] = external_source && (state_reg.channel == 4'(ch));
      end
   endgenerate

   // every field of the bundle from one process
   always_comb begin
      o_analog.input_onehot[3:0] = channel_onehot;
      o_analog.input_onehot[4] = (state_reg.source >= SOURCE_GROUND_LOW)
                                 && (state_reg.source <= SOURCE_GROUND_HIGH);
      o_analog.input_onehot[5] = state_reg.source == SOURCE_QUARTER_SUPPLY;
      o_analog.power = state_reg.power;
      o_analog.sampling = state_reg.state == ST_SAMPLE;
      o_analog.dac_code = state_reg.trial;

      // reference selection; codes 00 and 11 fall through to the pin
      case (state_reg.ref_sel)
         REF_SUPPLY: begin
            o_analog.ref_onehot = 3'b010;
         end
         REF_AMPLIFIER: begin
            o_analog.ref_onehot = 3'b100;
         end
         default: begin
            o_analog.ref_onehot = 3'b001;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin overrides: an analog pin gives up every digital function
   // requests on analog pins are dropped

   always_comb begin
      analog_pins = state_reg.pin_func[3:0];
      o_pin_digital_enable = ~analog_pins;
      o_pin_pullup_enable = i_pin_pullup_request & ~analog_pins;
      o_pin_drive_enable = i_pin_drive_request & ~analog_pins;
      // shorting the pin to an internal reference is the software's to avoid
      o_ref_pin_input_enable = state_reg.pin_func[4];
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus and status outputs
   // waitrequest is combinational

   always_comb begin
      o_avs_waitrequest = (i_avs_read || i_avs_write) && !state_reg.bus_ack;
      o_avs_readdata = state_reg.readdata;
      o_conversion_busy_flag = state_reg.busy;
      o_irq_request = state_reg.done_pulse;
   end

endmodule

`default_nettype wire

//--- core/sar_adc_control_pkg.sv
// shared constants and types for the converter control sequencer
package sar_adc_control_pkg;

   // register byte addresses on the avalon slave
   localparam logic [4:0] CONTROL_0_ADDR = 5'h00;
   localparam logic [4:0] CONTROL_1_ADDR = 5'h04;
   localparam logic [4:0] RESULT_HIGH_ADDR = 5'h08;
   localparam logic [4:0] RESULT_LOW_ADDR = 5'h0C;
   localparam logic [4:0] PIN_FUNCTION_ADDR = 5'h10;

   // converter_control_0 field positions
   localparam int CTRL0_START_BIT = 7;
   localparam int CTRL0_BUSY_BIT = 6;
   localparam int CTRL0_POWER_BIT = 5;
   localparam int CTRL0_ALIGN_BIT = 4;
   localparam int CTRL0_CHANNEL_LSB = 0;

   // converter_control_1 field positions
   localparam int CTRL1_SOURCE_LSB = 5;
   localparam int CTRL1_REF_LSB = 3;
   localparam int CTRL1_CLKDIV_LSB = 0;

   // reference select codes
   localparam logic [1:0] REF_SUPPLY = 2'h1;
   localparam logic [1:0] REF_AMPLIFIER = 2'h2;

   // input source select codes
   localparam logic [2:0] SOURCE_QUARTER_SUPPLY = 3'h4;
   localparam logic [2:0] SOURCE_GROUND_LOW = 3'h1;
   localparam logic [2:0] SOURCE_GROUND_HIGH = 3'h3;

   // highest implemented external channel code
   localparam logic [3:0] LAST_CHANNEL = 4'h3;

   // conversion phase lengths in conversion clock cycles
   localparam logic [3:0] SAMPLE_TICKS = 4'h4;
   localparam int RESULT_BITS = 10;

   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b100
   } seq_state_type;

   // everything the analog macro needs from this block
   typedef struct packed {
      logic power;             // converter_power_enable
      logic [2:0] ref_onehot;  // {amplifier, supply, external pin}
      logic [5:0] input_onehot; // {quarter supply, ground, an3..an0}; zero = floating
      logic sampling;          // sample switch closed
      logic [RESULT_BITS-1:0] dac_code; // trial code for the comparator
   } analog_ctrl_type;

   // all state of the sequencer
   typedef struct packed {
      seq_state_type state;
      logic start_bit;
      logic power;
      logic align;
      logic [3:0] channel;
      logic [2:0] source;
      logic [1:0] ref_sel;
      logic [2:0] clk_sel;
      logic [4:0] pin_func;
      logic busy;
      logic [7:0] result_high;
      logic [7:0] result_low;
      logic [6:0] div_count;
      logic [3:0] phase_count;
      logic [RESULT_BITS-1:0] trial;
      logic [RESULT_BITS-1:0] bit_mask;
      logic cmp_meta;
      logic cmp_sync;
      logic bus_ack;
      logic [31:0] readdata;
      logic done_pulse;
   } core_state_type;

endpackage

//--- bench/sar_adc_control_properties.sv
// concurrent checks on the converter control sequencer ports
`timescale 1ns/100ps
`default_nettype none

module sar_adc_control_properties
   import sar_adc_control_pkg::*;
(
   input wire logic i_core_clk, // system clock
   input wire logic i_reset, // asynchronous reset, active high
   input wire logic i_avs_read, // avalon read request
   input wire logic i_avs_write, // avalon write request
   input wire logic o_avs_waitrequest, // avalon wait request
   input wire logic [3:0] i_pin_pullup_request, // pull-high requests
   input wire logic [3:0] i_pin_drive_request, // driver requests
   input wire analog_ctrl_type o_analog, // analog macro controls
   input wire logic [3:0] o_pin_digital_enable, // digital path enables
   input wire logic [3:0] o_pin_pullup_enable, // pull-high enables
   input wire logic [3:0] o_pin_drive_enable, // driver enables
   input wire logic o_conversion_busy_flag, // busy flag
   input wire logic o_irq_request // completion pulse
);

   // one clock domain, so clocking and reset are given once
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);

   ////////////////////////////////////////////////////////////////////////////////
   // bus: a fresh request always gets exactly one wait cycle
   bus_one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus request waited more than one cycle");

   // routing: one reference only, at most one input source
   ref_onehot_a: assert property ($onehot(o_analog.ref_onehot))
      else $error("reference selection not one-hot");
   input_route_a: assert property ($onehot0(o_analog.input_onehot))
      else $error("more than one converter input connected");

   // pins: an analog pin loses pull-high and driver whatever the port logic asks
   pullup_off_a: assert property (o_pin_pullup_enable == (i_pin_pullup_request & o_pin_digital_enable))
      else $error("pull-high left on an analog pin");
   drive_off_a: assert property (o_pin_drive_enable == (i_pin_drive_request & o_pin_digital_enable))
      else $error("driver left on an analog pin");

   // sequence: sampling opens each conversion and never runs without busy
   sample_first_a: assert property ($rose(o_conversion_busy_flag) |-> o_analog.sampling [*4])
      else $error("sampling phase shorter than four cycles");
   sample_in_busy_a: assert property (o_analog.sampling |-> o_conversion_busy_flag)
      else $error("sampling outside a conversion");
   busy_powered_a: assert property (o_conversion_busy_flag |-> o_analog.power)
      else $error("conversion running unpowered");

   // completion: request pulse only as busy falls, one cycle long
   irq_at_done_a: assert property (o_irq_request |-> $fell(o_conversion_busy_flag))
      else $error("completion request without busy falling");
   irq_single_a: assert property (o_irq_request |=> !o_irq_request)
      else $error("completion request longer than one cycle");
   trial_start_a: assert property ($fell(o_analog.sampling) && o_conversion_busy_flag
      |-> o_analog.dac_code == 10'h200) else $error("first trial not mid-scale");

   ////////////////////////////////////////////////////////////////////////////////
   cover property ($fell(o_conversion_busy_flag));
   cover property (o_irq_request);
   cover property (i_avs_write && !o_avs_waitrequest);

endmodule

`default_nettype wire

//--- bench/sar_adc_control_sequencer_tb.sv
// self-checking testbench for the converter control sequencer
`timescale 1ns/100ps
`default_nettype none

module sar_adc_control_sequencer_tb
   import sar_adc_control_pkg::*;
;
   logic core_clk; // 25 MHz system clock
   logic reset; // active high reset
   logic [4:0] avs_address; // bus address
   logic avs_read; // bus read
   logic avs_write; // bus write
   logic [31:0] avs_writedata; // bus write data
   logic [31:0] avs_readdata; // bus read data
   logic avs_waitrequest; // bus wait
   logic comparator_high; // comparator decision
   logic [3:0] pullup_req; // port pull-high requests
   logic [3:0] drive_req; // port driver requests
   analog_ctrl_type analog; // analog controls
   logic [3:0] digital_en; // digital enables
   logic [3:0] pullup_en; // pull-high enables
   logic [3:0] drive_en; // driver enables
   logic ref_pin_en; // reference pin enable
   logic busy; // busy flag
   logic irq; // completion pulse
   int mismatches = 0; // failed comparisons
   int tests_run = 0; // comparisons made
   int busy_len = 0; // length of running busy
   int last_len = 0; // length of last busy
   int irq_count = 0; // completion pulses seen

   sar_adc_control_sequencer i_dut (.i_core_clk(core_clk), .i_reset(reset), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .i_avs_byteenable(4'hF), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
      .i_comparator_high(comparator_high), .i_pin_pullup_request(pullup_req), .i_pin_drive_request(drive_req),
      .o_analog(analog), .o_pin_digital_enable(digital_en), .o_pin_pullup_enable(pullup_en),
      .o_pin_drive_enable(drive_en), .o_ref_pin_input_enable(ref_pin_en), .o_conversion_busy_flag(busy),
      .o_irq_request(irq));

   ////////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // busy length and completion pulses, off the bus
   always @(posedge core_clk) begin
      if (busy === 1'b1) begin
         busy_len <= busy_len + 1;
      end else if (busy_len != 0) begin
         last_len <= busy_len;
         busy_len <= 0;
      end
      if (irq === 1'b1) begin
         irq_count <= irq_count + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon access; request held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_read <= ~wr;
      avs_write <= wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) mismatches++;
   endtask

   // write, then let decoded outputs settle before anyone looks
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] q;
      access(1'b1, a, d, q);
      @(negedge core_clk);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      access(1'b0, a, 8'h00, q);
      check(q, exp);
   endtask

   // full conversion: start pulse, busy length, request, aligned result
   task automatic convert(input logic [2:0] d, input logic comp, input logic al);
      logic [9:0] code;
      int n;
      int irq0;
      code = comp ? 10'h3FF : 10'h000;
      irq0 = irq_count;
      comparator_high <= comp;
      wr(CONTROL_1_ADDR, {5'h00, d});
      wr(CONTROL_0_ADDR, {3'b101, al, 4'h0});
      wr(CONTROL_0_ADDR, {3'b001, al, 4'h0});
      rd(CONTROL_0_ADDR, {24'h00_0000, 3'b011, al, 4'h0});
      n = 0;
      while (busy !== 1'b0 && n < 4000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 4000) mismatches++;
      @(posedge core_clk);
      check(last_len, 14 << d);
      check(irq_count - irq0, 1);
      rd(RESULT_HIGH_ADDR, al ? {30'h0000_0000, code[9:8]} : {24'h00_0000, code[9:2]});
      rd(RESULT_LOW_ADDR, al ? {24'h00_0000, code[7:0]} : {24'h00_0000, code[1:0], 6'h00});
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under 10000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      stop_test;
   end

   // main sequence
   initial begin
      reset = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      comparator_high = 1'b0;
      pullup_req = 4'h0;
      drive_req = 4'h0;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      // reset values, unmapped place, read-only busy
      rd(CONTROL_0_ADDR, 32'h0000_0000);
      rd(CONTROL_1_ADDR, 32'h0000_0000);
      check(analog.ref_onehot, 3'b001);
      check(analog.input_onehot, 6'h01);
      rd(5'h14, 32'h0000_0000);
      wr(CONTROL_0_ADDR, 8'h40);
      rd(CONTROL_0_ADDR, 32'h0000_0000);
      // every reference code, reference pin left unselected
      for (int r = 0; r < 4; r++) begin
         wr(CONTROL_1_ADDR, 8'(r << 3));
         check(analog.ref_onehot, (r == 1) ? 3'b010 : (r == 2) ? 3'b100 : 3'b001);
      end
      // every source and channel; never a real pin with a ground or quarter supply source code
      for (int s = 0; s < 8; s++) begin
         for (int c = 0; c < 16; c++) begin
            if (!(s >= 1 && s <= 4 && c < 4)) begin
               wr(CONTROL_1_ADDR, 8'(s << 5));
               wr(CONTROL_0_ADDR, 8'(c));
               check(analog.input_onehot, (s == 4) ? 6'h20 : (s >= 1 && s <= 3) ? 6'h10 :
                  (c < 4) ? 6'(1 << c) : 6'h00);
            end
         end
      end
      // analog pins 0 and 2 plus the reference pin
      @(posedge core_clk);
      pullup_req <= 4'hF;
      drive_req <= 4'hC;
      wr(PIN_FUNCTION_ADDR, 8'h15);
      check(digital_en, 4'hA);
      check(pullup_en, 4'hA);
      check(drive_en, 4'h8);
      check(ref_pin_en, 1'b1);
      // a start pulse without power is ignored
      wr(CONTROL_0_ADDR, 8'h80);
      wr(CONTROL_0_ADDR, 8'h00);
      check(busy, 1'b0);
      wr(CONTROL_0_ADDR, 8'h20);
      check(analog.power, 1'b1);
      repeat (20) @(posedge core_clk);
      // all dividers; periods from 1 to 128 system clocks
      for (int d = 0; d < 8; d++) begin
         convert(3'(d), 1'(d), 1'(d >> 1));
      end
      // power off: results kept
      comparator_high <= 1'b0;
      wr(CONTROL_0_ADDR, 8'hB0);
      wr(CONTROL_0_ADDR, 8'h30);
      repeat (600) @(posedge core_clk);
      wr(CONTROL_0_ADDR, 8'h10);
      check(busy, 1'b0);
      repeat (1300) @(posedge core_clk);
      check(irq_count, 8);
      check(analog.power, 1'b0);
      rd(RESULT_HIGH_ADDR, 32'h0000_0003);
      rd(RESULT_LOW_ADDR, 32'h0000_00FF);
      stop_test;
   end

endmodule

bind sar_adc_control_sequencer sar_adc_control_properties i_props (.i_core_clk(i_core_clk), .i_reset(i_reset),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
   .i_pin_pullup_request(i_pin_pullup_request), .i_pin_drive_request(i_pin_drive_request), .o_analog(o_analog),
   .o_pin_digital_enable(o_pin_digital_enable), .o_pin_pullup_enable(o_pin_pullup_enable),
   .o_pin_drive_enable(o_pin_drive_enable), .o_conversion_busy_flag(o_conversion_busy_flag),
   .o_irq_request(o_irq_request));

`default_nettype wire
